// File: logic/event_router_defs.svh
// event router constants: selection codes and reset values
// assumes inclusion by the event router package and design file only
`ifndef EVENT_ROUTER_DEFS_SVH
`define EVENT_ROUTER_DEFS_SVH

`define ER_CODE_W      4
`define ER_SRC_NONE    4'h0
`define ER_CH_NONE     4'h0
`define ER_SEL_RST     4'h0
`define ER_CODE_MAX    15

`endif

// File: logic/event_router_pkg.sv
// event router types shared by the design and its bench
// assumes the constants header is on the include path
`default_nettype none
`include "event_router_defs.svh"

package event_router_pkg;
  typedef logic [`ER_CODE_W-1:0] src_code_t;  // 0 none, 1..gens, gens+1 software
  typedef logic [`ER_CODE_W-1:0] ch_code_t;   // 0 none, 1..channels
  typedef logic [7:0]            user_idx_t;
endpackage : event_router_pkg
`default_nettype wire

// File: logic/event_router.sv
// event router: channel source muxes, sync/async subchannels, user muxes, pin outputs
// assumes generator inputs may be asynchronous where GEN_ASYNC_MASK says so;
// configuration strobes are synchronous to mclk
//
// Summary of operation
// [RULE1] up to eight channels run in parallel, each with its own event
// [RULE2] one generator drives a channel; any number of users may listen
// [RULE3] routing has no dependence on sleep state; async path needs no clock
// [RULE4] a channel carries one event only; generators are never combined
// [RULE5] software events enter channels like any other generator
// [RULE6] per-channel source select picks the event placed onto the channel
// [RULE7] each channel has async and sync subchannels for matching users
// [RULE8] async sources pass a synchroniser before the sync subchannel
// [RULE9] async generators hold events at least one clock for sync users
// [RULE10] synchroniser adds two to three clock cycles of latency
// [RULE11] one event output per I/O port drives a routed event to a pin
// [RULE12] each user has its own channel select mux
// [RULE13] channels accept both synchronous and asynchronous generators
// [RULE14] software sets peripherals, then channel source, then user muxes
// [RULE15] after reset no channel connects to any generator
// [RULE16] each user is hardwired to one subchannel, not configurable
// [RULE17] reset clears synchroniser stages and user selections
`timescale 1ns/1ps
`default_nettype none
`include "event_router_defs.svh"

module event_router #(
  parameter int              NUM_CH          = 8,
  parameter int              NUM_GEN         = 8,
  parameter int              NUM_USER        = 8,
  parameter int              NUM_PORT        = 3,
  parameter logic [NUM_GEN-1:0]  GEN_ASYNC_MASK  = '0,
  parameter logic [NUM_USER-1:0] USER_ASYNC_MASK = '0
) (
  input  wire logic                        mclk,              // peripheral clock
  input  wire logic                        rst_n,             // sync reset, active low
  input  wire logic [NUM_GEN-1:0]          gen_event,         // generator event levels
  input  wire logic [NUM_CH-1:0]           sw_event,          // software event per channel
  input  wire logic                        cfg_ch_wr,         // channel source write strobe
  input  wire event_router_pkg::ch_code_t  cfg_ch_idx,        // channel index 0..NUM_CH-1
  input  wire event_router_pkg::src_code_t cfg_ch_src,        // new source code
  input  wire logic                        cfg_user_wr,       // user select write strobe
  input  wire event_router_pkg::user_idx_t cfg_user_idx,      // user index, pins after users
  input  wire event_router_pkg::ch_code_t  cfg_user_ch,       // channel code, 0 none
  output var  logic [NUM_USER-1:0]         user_event,        // event to each user
  output var  logic [NUM_PORT-1:0]         event_pin_output   // event to each port pin
);
  import event_router_pkg::*;

  localparam int NSEL = NUM_USER + NUM_PORT;
  localparam src_code_t SRC_SW = src_code_t'(NUM_GEN + 1);

  initial begin
    if (NUM_CH < 1 || NUM_CH >= `ER_CODE_MAX || NUM_GEN + 1 >= `ER_CODE_MAX || NSEL > 256 || NUM_USER < 1
        || NUM_PORT < 1)
      $error("event_router: parameters out of range");
  end

  // configuration state
  // pins sit in the select array right after the users
  src_code_t src_q [NUM_CH];
  src_code_t src_d [NUM_CH];
  ch_code_t  sel_q [NSEL];
  ch_code_t  sel_d [NSEL];

  always_comb
  begin
    for (int c = 0; c < NUM_CH; c++)
    begin
      src_d[c] = src_q[c];
      if (!rst_n)
        src_d[c] = `ER_SEL_RST;                                  // RULE15
      else if (cfg_ch_wr && cfg_ch_idx == ch_code_t'(c))
        src_d[c] = cfg_ch_src;                                   // RULE6
    end
    for (int u = 0; u < NSEL; u++)
    begin
      sel_d[u] = sel_q[u];
      if (!rst_n)
        sel_d[u] = `ER_SEL_RST;                                  // RULE17
      else if (cfg_user_wr && cfg_user_idx == user_idx_t'(u))
        sel_d[u] = cfg_user_ch;                                  // RULE12
    end
  end

  always_ff @(posedge mclk)
  begin
    src_q <= src_d;
    sel_q <= sel_d;
  end

  function automatic logic src_is_gen(input src_code_t code);
    return code != `ER_SRC_NONE && code <= src_code_t'(NUM_GEN);
  endfunction : src_is_gen

  function automatic logic pick_ch(input logic [NUM_CH-1:0] v, input ch_code_t code);
    logic r;
    r = 1'b0;
    for (int c = 0; c < NUM_CH; c++)
      if (code == ch_code_t'(c + 1))
        r = v[c];
    return r;
  endfunction : pick_ch

  // channel source muxes: at most one source per channel, none for code 0 or unused codes
  logic [NUM_CH-1:0] raw;
  logic [NUM_CH-1:0] is_async;

  always_comb
  begin
    for (int c = 0; c < NUM_CH; c++)
    begin
      raw[c]      = 1'b0;
      is_async[c] = 1'b0;
      for (int g = 0; g < NUM_GEN; g++)
        if (src_q[c] == src_code_t'(g + 1))
        begin
          raw[c]      = gen_event[g];                            // RULE4 RULE13
          is_async[c] = GEN_ASYNC_MASK[g];
        end
      if (src_q[c] == SRC_SW)
        raw[c] = sw_event[c];                                    // RULE5
    end
  end

  // subchannels; async one is the raw channel, no clock involved
  logic [NUM_CH-1:0]   meta_q, meta_d, stage2_q, stage2_d, direct_q, direct_d;
  logic [NUM_CH-1:0]   sync_ch;
  logic [NUM_USER-1:0] user_q, user_d;

  always_comb
  begin
    meta_d   = rst_n ? (raw & is_async) : '0;                    // RULE8 RULE17
    stage2_d = rst_n ? meta_q : '0;                              // RULE10
    // async sources stay out of the direct flop; it would sample them unsynchronised
    direct_d = rst_n ? (raw & ~is_async) : '0;                  // RULE8
    for (int c = 0; c < NUM_CH; c++)
      sync_ch[c] = is_async[c] ? stage2_q[c] : direct_q[c];      // RULE7 RULE1
    for (int u = 0; u < NUM_USER; u++)
      user_d[u] = rst_n & pick_ch(sync_ch, sel_q[u]);            // RULE2 RULE12
  end

  always_ff @(posedge mclk)
  begin
    meta_q   <= meta_d;
    stage2_q <= stage2_d;
    direct_q <= direct_d;
    user_q   <= user_d;
  end

  // async users and pins bypass the clock so they still work with clocks stopped
  always_comb
  begin
    for (int u = 0; u < NUM_USER; u++)
      user_event[u] = USER_ASYNC_MASK[u] ? pick_ch(raw, sel_q[u]) : user_q[u];   // RULE16 RULE3
    for (int p = 0; p < NUM_PORT; p++)
      event_pin_output[p] = pick_ch(raw, sel_q[NUM_USER + p]);                   // RULE11
  end

  // checks
  // channel 0 and the edge users stand for all indices; the logic is the same per index
  a_reset_clears: assert property (@(posedge mclk) // RULE17
    !rst_n |=> (meta_q == '0 && stage2_q == '0 && user_q == '0
    && src_q[0] == `ER_SRC_NONE && sel_q[0] == `ER_CH_NONE))
    else $error("reset left routing state set");

  a_no_source: assert property (@(posedge mclk) disable iff (!rst_n) // RULE15
    src_q[0] == `ER_SRC_NONE |-> !raw[0] && !is_async[0])
    else $error("unconnected channel carries an event");

  a_sync_chain: assert property (@(posedge mclk) disable iff (!rst_n) // RULE8
    is_async[0] && raw[0] |=> meta_q[0] ##1 stage2_q[0])
    else $error("async event did not cross the synchroniser");

  a_sync_latency: assert property (@(posedge mclk) disable iff (!rst_n) // RULE10
    is_async[0] && sel_q[0] == ch_code_t'(1) && $stable(sel_q[0]) && raw[0]
      ##1 is_async[0] && $stable(sel_q[0]) ##1 is_async[0] && $stable(sel_q[0])
      |=> user_q[0])
    else $error("sync user missed event after three cycles");

  a_direct_path: assert property (@(posedge mclk) disable iff (!rst_n) // RULE13
    !is_async[0] |=> direct_q[0] == $past(raw[0]))
    else $error("sync source not registered onto channel");

  a_user_mux: assert property (@(posedge mclk) disable iff (!rst_n) // RULE12
    !cfg_user_wr ##1 sel_q[0] == ch_code_t'(1) |=> user_q[0] == $past(sync_ch[0]))
    else $error("user does not follow its selected channel");

  a_sw_event: assert property (@(posedge mclk) disable iff (!rst_n) // RULE5
    src_q[0] == SRC_SW |-> raw[0] == sw_event[0] && !is_async[0])
    else $error("software event not placed onto channel");

  a_ch_write: assert property (@(posedge mclk) disable iff (!rst_n) // RULE6
    cfg_ch_wr && cfg_ch_idx == ch_code_t'(0) ##1 rst_n |-> src_q[0] == $past(cfg_ch_src))
    else $error("channel source write not applied");

  a_user_write: assert property (@(posedge mclk) disable iff (!rst_n) // RULE12
    cfg_user_wr && cfg_user_idx == user_idx_t'(0) ##1 rst_n |-> sel_q[0] == $past(cfg_user_ch))
    else $error("user select write not applied");

  a_async_gate: assert property (@(posedge mclk) disable iff (!rst_n) // RULE8
    !is_async[0] |=> !meta_q[0])
    else $error("sync source entered the synchroniser");

  a_direct_gate: assert property (@(posedge mclk) disable iff (!rst_n) // RULE8
    is_async[0] |=> !direct_q[0])
    else $error("async source sampled without synchroniser");

  a_user_none: assert property (@(posedge mclk) disable iff (!rst_n) // RULE12
    sel_q[0] == `ER_CH_NONE |=> !user_q[0])
    else $error("unselected user received an event");

  a_pin_route: assert property (@(posedge mclk) disable iff (!rst_n) // RULE11
    sel_q[NUM_USER] == ch_code_t'(1) |-> event_pin_output[0] == raw[0])
    else $error("pin output does not follow its channel");

  a_pin_none: assert property (@(posedge mclk) disable iff (!rst_n) // RULE15
    sel_q[NUM_USER] == `ER_CH_NONE |-> !event_pin_output[0])
    else $error("unrouted pin output is active");

  a_async_user: assert property (@(posedge mclk) disable iff (!rst_n) // RULE16
    USER_ASYNC_MASK[NUM_USER-1] && sel_q[NUM_USER-1] == ch_code_t'(1) |-> user_event[NUM_USER-1] == raw[0])
    else $error("async user not on the async subchannel");

  c_async_route: cover property (@(posedge mclk) disable iff (!rst_n) is_async[0] && raw[0] ##2 stage2_q[0]);
  c_sw_event:    cover property (@(posedge mclk) disable iff (!rst_n) src_q[0] == SRC_SW && sw_event[0]);
  c_pin_out:     cover property (@(posedge mclk) disable iff (!rst_n) event_pin_output[0]);
  c_sync_user:   cover property (@(posedge mclk) disable iff (!rst_n) user_q[0]);
endmodule : event_router

`default_nettype wire

// File: dv/event_gen_model.sv
// generator model: peripheral event sources in front of the router
// assumes the bench hands it the next levels and how long each stands
`timescale 1ns/1ps
`default_nettype none
module event_gen_model (
  input  wire logic       mclk,      // peripheral clock
  input  wire logic [7:0] nxt,       // next event levels
  input  wire logic [1:0] hold,      // extra cycles a level stands
  output var  logic [7:0] gen_event  // event levels to the router
);
  logic [1:0] cnt;
  initial
  begin
    cnt = 2'h0;
    gen_event = 8'h00;
  end
  // async sources change here too, so every level lasts a full clock
  always @(negedge mclk)
  begin
    if (cnt == 2'h0) gen_event <= nxt;
    cnt <= (cnt >= hold) ? 2'h0 : cnt + 2'h1;
  end
endmodule : event_gen_model
`default_nettype wire

// File: dv/event_router_tb.sv
// bench for the event router: random routing, reference model, reset checks
// assumes the generator model and the router package are compiled first
`timescale 1ns/1ps
`default_nettype none
module event_router_tb;
  import event_router_pkg::*;
  logic       mclk, rst_n, cfg_ch_wr, cfg_user_wr;
  logic [7:0] nxt, sw_event, gen_event, user_event, h1, h2, h3;
  logic [2:0] event_pin_output;
  logic [1:0] hold;
  ch_code_t   cfg_ch_idx, cfg_user_ch;
  src_code_t  cfg_ch_src;
  user_idx_t  cfg_user_idx;
  int         src_sel[8], usr_sel[11], bad_count, n_compared, cyc, quiet;
  event_router #(.GEN_ASYNC_MASK(8'hF0), .USER_ASYNC_MASK(8'hF0)) u_event_router (.mclk(mclk), .rst_n(rst_n),
    .gen_event(gen_event), .sw_event(sw_event), .cfg_ch_wr(cfg_ch_wr), .cfg_ch_idx(cfg_ch_idx),
    .cfg_ch_src(cfg_ch_src), .cfg_user_wr(cfg_user_wr), .cfg_user_idx(cfg_user_idx), .cfg_user_ch(cfg_user_ch),
    .user_event(user_event), .event_pin_output(event_pin_output));
  event_gen_model u_event_gen_model (.mclk(mclk), .nxt(nxt), .hold(hold), .gen_event(gen_event));
  function automatic logic chv(int c);
    chv = (src_sel[c] inside {[1:8]}) ? gen_event[src_sel[c]-1] : (src_sel[c] == 9 && sw_event[c]);
  endfunction : chv
  function automatic logic selv(int u);
    selv = (usr_sel[u] inside {[1:8]}) ? chv(usr_sel[u]-1) : 1'b0;
  endfunction : selv
  // sources 5..8 are the async generators of this bench
  function automatic logic slow(int u);
    slow = (usr_sel[u] inside {[1:8]}) && (src_sel[usr_sel[u]-1] inside {[5:8]});
  endfunction : slow
  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done
  // sync users lag two edges from sync sources, three through the synchroniser;
  // skipped while selects settle
  always @(posedge mclk)
  begin
    cyc++;
    for (int u = 0; u < 8; u++) h1[u] <= selv(u);
    h2 <= h1;
    h3 <= h2;
    quiet = (!rst_n || cfg_ch_wr || cfg_user_wr) ? 0 : quiet + 1;
    if (!rst_n)
    begin
      src_sel = '{default: 0};
      usr_sel = '{default: 0};
    end
    else
    begin
      if (cfg_ch_wr && cfg_ch_idx < 4'h8) src_sel[cfg_ch_idx] = cfg_ch_src;
      if (cfg_user_wr && cfg_user_idx < 8'h0B) usr_sel[cfg_user_idx] = cfg_user_ch;
    end
  end
  task automatic step(logic cfg);
    logic [7:0] e;
    @(negedge mclk);
    for (int u = 0; u < 8; u++)
      e[u] = (u > 3) ? selv(u) : ((quiet > 2) ? (slow(u) ? h3[u] : h2[u]) : user_event[u]);
    check("user_event", user_event, e);
    check("event_pin_output", {5'h00, event_pin_output}, {5'h00, selv(10), selv(9), selv(8)});
    nxt <= 8'($urandom);
    sw_event <= 8'($urandom);
    hold <= 2'($urandom % 3);
    cfg_ch_wr <= cfg;
    cfg_user_wr <= cfg;
    cfg_ch_idx <= 4'($urandom % 10);
    cfg_ch_src <= 4'($urandom % 11);
    cfg_user_idx <= 8'($urandom % 12);
    cfg_user_ch <= 4'($urandom % 10);
  endtask : step
  initial
  begin
    wait (cyc == 2000);
    bad_count++;
    test_done();
  end
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial
  begin
    void'($urandom(32'hC9D3));
    {rst_n, cfg_ch_wr, cfg_user_wr, nxt, sw_event, hold} = '0;
    {cfg_ch_idx, cfg_ch_src, cfg_user_idx, cfg_user_ch} = '0;
    repeat (10) step(1'b0);
    check("reset", user_event, 8'h00);
    rst_n <= 1'b1;
    repeat (6) step(1'b0);
    check("idle", user_event, 8'h00);
    $display("test reset done");
    // setup order: generator already running, channel source next, user select last
    @(negedge mclk);
    cfg_ch_wr  <= 1'b1;
    cfg_ch_idx <= 4'h0;
    cfg_ch_src <= 4'h1;
    @(negedge mclk);
    cfg_ch_wr    <= 1'b0;
    cfg_user_wr  <= 1'b1;
    cfg_user_idx <= 8'h00;
    cfg_user_ch  <= 4'h1;
    @(negedge mclk);
    cfg_user_wr <= 1'b0;
    repeat (6) step(1'b0);
    check("setup user", {7'h00, user_event[0]}, {7'h00, h2[0]});
    $display("test setup order done");
    repeat (40)
    begin
      repeat (3) step(1'b1);
      repeat (12) step(1'b0);
    end
    $display("test routing done");
    rst_n <= 1'b0;
    repeat (2) step(1'b0);
    check("mid reset", user_event, 8'h00);
    rst_n <= 1'b1;
    repeat (6) step(1'b0);
    check("after reset", user_event, 8'h00);
    check("after reset pins", {5'h00, event_pin_output}, 8'h00);
    $display("test mid-run reset done");
    test_done();
  end
endmodule : event_router_tb
`default_nettype wire
